// file: pgp_port.sv
// Eight pin general I/O port with pin function routing.
//
// Functional notes
// - Eight-bit output latch, reset to zero.
// - Output pins read back latched data.
// - Input pins read back sampled pin level.
// - Direction bit one means output.
// - Alternate function overrides direction and latch in the pin drive, not in reads.
// - Direction register write-only, reads all ones.
// - Reset makes every pin an input except pin 2, which drives the reset output.
// - Pull-up select turns input pull-up on.
// - Reset turns every pull-up off.
// - Mode register read/write, resets to 04.
// - Mode bit 7 routes low event input.
// - Mode bit 6 routes high event input.
// - Mode bit 5 picks watchdog clock source.
// - Mode bit 4 enables capture noise canceller.
// - Mode bit 3 selects external interrupt zero.
// - Mode bit 2 routes reset output, default on.
// - Mode bit 1 routes count direction input.
// - Mode bit 0 routes PWM output.
`timescale 1ns/1ps
`include "pgp_cfg.svh"
module pgp_port #(
    parameter int WDOG_SYS_DIV = `PGP_WDOG_SYS_DIV,
    parameter int WDOG_SUB_DIV = `PGP_WDOG_SUB_DIV,
    parameter int FILT_LEN = `PGP_FILT_LEN
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire pgp_pkg::pgp_addr_t reg_addr,
    input wire pgp_pkg::pgp_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output pgp_pkg::pgp_byte_t reg_rdata,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pull_up,
    input wire logic p4_3_pin_in,
    input wire logic capture_trigger_input,
    input wire logic subclock_in,
    input wire logic pwm_in,
    input wire logic reset_out_req,
    output logic event_count_low_input,
    output logic event_count_high_input,
    output logic count_direction_input,
    output logic capture_trigger_filtered,
    output logic ext_external_interrupt_zero_select_n,
    output logic p4_3_gpio_in,
    output logic watchdog_clock_select,
    output logic watchdog_tick
);
    import pgp_pkg::*;

    // ************************************************************
    // Local declarations
    // ************************************************************
    localparam int SYS_W = $clog2(WDOG_SYS_DIV);
    localparam int SUB_W = $clog2(WDOG_SUB_DIV);

    pgp_byte_t port_data_latch_q;
    pgp_byte_t pin_direction_q;
    pgp_byte_t pull_up_enable_q;
    pgp_byte_t pin_function_mode_q;
    pgp_byte_t reg_rdata_q;
    pgp_byte_t pin_out_q;
    pgp_byte_t pin_out_d;
    pgp_byte_t pin_oe_q;
    pgp_byte_t pin_oe_d;
    pgp_byte_t pin_pull_up_q;
    pgp_byte_t pin_pull_up_d;
    pgp_byte_t pin_sync;
    pgp_byte_t port_read_d;
    pgp_reg_sel_t wr_sel;
    pgp_reg_sel_t rd_sel;
    logic p4_3_sync;
    logic capture_sync;
    logic subclock_sync;
    logic subclock_prev_q;
    logic subclock_rise;
    logic [SYS_W-1:0] sys_cnt_q;
    logic [SUB_W-1:0] sub_cnt_q;
    logic sys_tick;
    logic sub_tick;
    logic evt_low_q;
    logic evt_high_q;
    logic count_dir_q;
    logic ext_external_interrupt_zero_select_n_q;
    logic p4_3_gpio_q;
    logic wdog_sel_q;
    logic wdog_tick_q;

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic pgp_reg_sel_t pgp_decode(input pgp_addr_t a);
        pgp_reg_sel_t s;
        s = PGP_SEL_NONE;
        case (a)
            `PGP_ADDR_MODE: s = PGP_SEL_MODE;
            `PGP_ADDR_DATA: s = PGP_SEL_DATA;
            `PGP_ADDR_PULL: s = PGP_SEL_PULL;
            `PGP_ADDR_DIR: s = PGP_SEL_DIR;
            default: s = PGP_SEL_NONE;
        endcase
        return s;
    endfunction

    assign wr_sel = reg_wr ? pgp_decode(reg_addr) : PGP_SEL_NONE;
    assign rd_sel = reg_rd ? pgp_decode(reg_addr) : PGP_SEL_NONE;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    pgp_sync #(
        .WIDTH(11)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({subclock_in, capture_trigger_input, p4_3_pin_in,
            pin_in}),
        .sync_out({subclock_sync, capture_sync, p4_3_sync, pin_sync})
    );

    // ************************************************************
    // Software registers
    // ************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            port_data_latch_q <= `PGP_RST_DATA;
        end
        else if (wr_sel == PGP_SEL_DATA)
        begin
            port_data_latch_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pin_direction_q <= `PGP_RST_DIR;
        end
        else if (wr_sel == PGP_SEL_DIR)
        begin
            pin_direction_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pull_up_enable_q <= `PGP_RST_PULL;
        end
        else if (wr_sel == PGP_SEL_PULL)
        begin
            pull_up_enable_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pin_function_mode_q <= `PGP_RST_MODE;
        end
        else if (wr_sel == PGP_SEL_MODE)
        begin
            pin_function_mode_q <= reg_wdata;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Output pins give back the latch, input pins the pin level.
    assign port_read_d = (pin_direction_q & port_data_latch_q)
        | (~pin_direction_q & pin_sync);

    // Read data stand for exactly the cycle after the read strobe.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            reg_rdata_q <= `PGP_RD_UNMAPPED;
        end
        else
        begin
            case (rd_sel)
                PGP_SEL_MODE: reg_rdata_q <= pin_function_mode_q;
                PGP_SEL_DATA: reg_rdata_q <= port_read_d;
                PGP_SEL_PULL: reg_rdata_q <= pull_up_enable_q;
                PGP_SEL_DIR: reg_rdata_q <= `PGP_DIR_READ;
                default: reg_rdata_q <= `PGP_RD_UNMAPPED;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_q;

    // ************************************************************
    // Pin drive and pull-up
    // ************************************************************
    always_comb
    begin
        // General I/O: direction and latch drive the pin.
        pin_oe_d = pin_direction_q;
        pin_out_d = port_data_latch_q;
        // Pins given to an input function are never driven.
        if (pin_function_mode_q[`PGP_B_EVT_LOW])
        begin
            pin_oe_d[`PGP_B_EVT_LOW] = 1'b0;
            pin_out_d[`PGP_B_EVT_LOW] = 1'b0;
        end
        if (pin_function_mode_q[`PGP_B_EVT_HIGH])
        begin
            pin_oe_d[`PGP_B_EVT_HIGH] = 1'b0;
            pin_out_d[`PGP_B_EVT_HIGH] = 1'b0;
        end
        if (pin_function_mode_q[`PGP_B_COUNT_DIR])
        begin
            pin_oe_d[`PGP_B_COUNT_DIR] = 1'b0;
            pin_out_d[`PGP_B_COUNT_DIR] = 1'b0;
        end
        // The reset output is active low.
        if (pin_function_mode_q[`PGP_B_RESET_OUT])
        begin
            pin_oe_d[`PGP_B_RESET_OUT] = 1'b1;
            pin_out_d[`PGP_B_RESET_OUT] = ~reset_out_req;
        end
        if (pin_function_mode_q[`PGP_B_PWM_OUT])
        begin
            pin_oe_d[`PGP_B_PWM_OUT] = 1'b1;
            pin_out_d[`PGP_B_PWM_OUT] = pwm_in;
        end
        // Pull-up only on input pins that are not being driven.
        pin_pull_up_d = pull_up_enable_q
            & ~pin_direction_q & ~pin_oe_d;
    end

    // Reset holds the reset output pin driven low.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pin_out_q <= `PGP_RST_PIN_OUT;
            pin_oe_q <= `PGP_RST_PIN_OE;
            pin_pull_up_q <= `PGP_RST_PULL;
        end
        else
        begin
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
            pin_pull_up_q <= pin_pull_up_d;
        end
    end

    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;
    assign pin_pull_up = pin_pull_up_q;

    // ************************************************************
    // Alternate function inputs
    // ************************************************************
    // An input function that is not selected reads as low.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            evt_low_q <= 1'b0;
            evt_high_q <= 1'b0;
            count_dir_q <= 1'b0;
        end
        else
        begin
            evt_low_q <= pin_function_mode_q[`PGP_B_EVT_LOW]
                & pin_sync[`PGP_B_EVT_LOW];
            evt_high_q <= pin_function_mode_q[`PGP_B_EVT_HIGH]
                & pin_sync[`PGP_B_EVT_HIGH];
            count_dir_q <= pin_function_mode_q[`PGP_B_COUNT_DIR]
                & pin_sync[`PGP_B_COUNT_DIR];
        end
    end

    assign event_count_low_input = evt_low_q;
    assign event_count_high_input = evt_high_q;
    assign count_direction_input = count_dir_q;

    // The other port's pin 3 goes either to the interrupt or to
    // its general input; the unused side rests inactive.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ext_external_interrupt_zero_select_n_q <= 1'b1;
            p4_3_gpio_q <= 1'b0;
        end
        else if (pin_function_mode_q[`PGP_B_EXT_EXTERNAL_INTERRUPT_ZERO_SELECT])
        begin
            ext_external_interrupt_zero_select_n_q <= p4_3_sync;
            p4_3_gpio_q <= 1'b0;
        end
        else
        begin
            ext_external_interrupt_zero_select_n_q <= 1'b1;
            p4_3_gpio_q <= p4_3_sync;
        end
    end

    assign ext_external_interrupt_zero_select_n = ext_external_interrupt_zero_select_n_q;
    assign p4_3_gpio_in = p4_3_gpio_q;

    // ************************************************************
    // Capture trigger noise canceller
    // ************************************************************
    pgp_noise_filter #(
        .FILT_LEN(FILT_LEN)
    ) u_filter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .enable(pin_function_mode_q[`PGP_B_NOISE_EN]),
        .raw_in(capture_sync),
        .filt_q(capture_trigger_filtered)
    );

    // ************************************************************
    // Watchdog source clock
    // ************************************************************
    // System clock divider.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sys_cnt_q <= '0;
        end
        else if (sys_tick)
        begin
            sys_cnt_q <= '0;
        end
        else
        begin
            sys_cnt_q <= sys_cnt_q + SYS_W'(1);
        end
    end

    assign sys_tick = (sys_cnt_q == SYS_W'(WDOG_SYS_DIV - 1));

    // Subclock edges, taken after the synchroniser.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            subclock_prev_q <= 1'b0;
        end
        else
        begin
            subclock_prev_q <= subclock_sync;
        end
    end

    assign subclock_rise = subclock_sync & ~subclock_prev_q;

    // Subclock divider.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sub_cnt_q <= '0;
        end
        else if (sub_tick)
        begin
            sub_cnt_q <= '0;
        end
        else if (subclock_rise)
        begin
            sub_cnt_q <= sub_cnt_q + SUB_W'(1);
        end
    end

    assign sub_tick = subclock_rise
        & (sub_cnt_q == SUB_W'(WDOG_SUB_DIV - 1));

    // One-cycle tick from the selected source.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wdog_sel_q <= 1'b0;
            wdog_tick_q <= 1'b0;
        end
        else
        begin
            wdog_sel_q <= pin_function_mode_q[`PGP_B_WDOG_SEL];
            wdog_tick_q <= pin_function_mode_q[`PGP_B_WDOG_SEL]
                ? sub_tick : sys_tick;
        end
    end

    assign watchdog_clock_select = wdog_sel_q;
    assign watchdog_tick = wdog_tick_q;
endmodule // pgp_port

// file: pgp_cfg.svh
// Constants for the port pin function and general I/O block.
`ifndef PGP_CFG_SVH
`define PGP_CFG_SVH

// ****************************************************************
// Register addresses and reset values
// ****************************************************************
`define PGP_ADDR_W 16
`define PGP_ADDR_MODE 16'hffca
`define PGP_ADDR_DATA 16'hffd6
`define PGP_ADDR_PULL 16'hffe1
`define PGP_ADDR_DIR 16'hffe6
`define PGP_RST_MODE 8'h04
`define PGP_RST_DATA 8'h00
`define PGP_RST_PULL 8'h00
`define PGP_RST_DIR 8'h00
`define PGP_RST_PIN_OUT 8'h00
`define PGP_RST_PIN_OE 8'h04
`define PGP_DIR_READ 8'hff
`define PGP_RD_UNMAPPED 8'h00

// ****************************************************************
// Mode bit positions; each bit but 4 and 5 equals the pin it routes
// ****************************************************************
`define PGP_B_PWM_OUT 0
`define PGP_B_COUNT_DIR 1
`define PGP_B_RESET_OUT 2
`define PGP_B_EXT_EXTERNAL_INTERRUPT_ZERO_SELECT 3
`define PGP_B_NOISE_EN 4
`define PGP_B_WDOG_SEL 5
`define PGP_B_EVT_HIGH 6
`define PGP_B_EVT_LOW 7

// ****************************************************************
// Dividers and filter length
// ****************************************************************
`define PGP_WDOG_SYS_DIV 8192
`define PGP_WDOG_SUB_DIV 32
`define PGP_FILT_LEN 4

`endif

// file: pgp_pkg.sv
// Types shared by the port pin function and general I/O block.
package pgp_pkg;
    typedef logic [7:0] pgp_byte_t;
    typedef logic [15:0] pgp_addr_t;
    typedef enum {
        PGP_SEL_NONE,
        PGP_SEL_MODE,
        PGP_SEL_DATA,
        PGP_SEL_PULL,
        PGP_SEL_DIR
    } pgp_reg_sel_t;
endpackage

// file: pgp_sync.sv
// Two flip-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module pgp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // pgp_sync

// file: pgp_noise_filter.sv
// Noise canceller for the capture trigger input, with a bypass.
`timescale 1ns/1ps
module pgp_noise_filter #(
    parameter int FILT_LEN = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic raw_in,
    output logic filt_q
);
    localparam int CW = $clog2(FILT_LEN + 1);
    logic [CW-1:0] stable_q;

    // A new level passes only after FILT_LEN equal samples in a row.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            stable_q <= '0;
            filt_q <= 1'b0;
        end
        else if (!enable)
        begin
            stable_q <= '0;
            filt_q <= raw_in;
        end
        else if (raw_in == filt_q)
        begin
            stable_q <= '0;
        end
        else if (stable_q == CW'(FILT_LEN - 1))
        begin
            stable_q <= '0;
            filt_q <= raw_in;
        end
        else
        begin
            stable_q <= stable_q + CW'(1);
        end
    end
endmodule // pgp_noise_filter

// file: pgp_port_checker.sv
// Concurrent assertions for the port pin function block.
`timescale 1ns/1ps
`include "pgp_cfg.svh"
module pgp_port_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire pgp_pkg::pgp_addr_t reg_addr,
    input wire pgp_pkg::pgp_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire pgp_pkg::pgp_byte_t reg_rdata,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pull_up,
    input wire logic pwm_in,
    input wire logic reset_out_req,
    input wire logic ext_external_interrupt_zero_select_n,
    input wire logic p4_3_gpio_in,
    input wire logic watchdog_clock_select
);
    import pgp_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Shadow of the mode register, kept from the bus writes.
    pgp_byte_t mode_q;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            mode_q <= `PGP_RST_MODE;
        else if (reg_wr && reg_addr == `PGP_ADDR_MODE)
            mode_q <= reg_wdata;
    end
    property p_dir_read;
        reg_rd && reg_addr == `PGP_ADDR_DIR |=> reg_rdata == 8'hff;
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("Direction read is not all ones.");
    property p_mode_rw;
        reg_rd && reg_addr == `PGP_ADDR_MODE |=> reg_rdata == $past(mode_q);
    endproperty
    a_mode_rw: assert property (p_mode_rw)
        else $error("Mode read differs from last write.");
    property p_pwm;
        $past(mode_q[0]) && $past(rst_n)
            |-> pin_oe[0] && pin_out[0] == $past(pwm_in);
    endproperty
    a_pwm: assert property (p_pwm)
        else $error("Pin 0 does not carry the PWM.");
    property p_reset_output_select;
        $past(mode_q[2]) && $past(rst_n)
            |-> pin_oe[2] && pin_out[2] == !$past(reset_out_req);
    endproperty
    a_reset_output_select: assert property (p_reset_output_select)
        else $error("Pin 2 does not carry the reset output.");
    property p_alt_oe;
        (pin_oe & $past(mode_q) & 8'hc2) == 8'h00;
    endproperty
    a_alt_oe: assert property (p_alt_oe)
        else $error("Alternate input pin is driven.");
    property p_pull;
        (pin_pull_up & pin_oe) == 8'h00;
    endproperty
    a_pull: assert property (p_pull)
        else $error("Pull-up on a driven pin.");
    property p_irq;
        $past(mode_q[3]) ? !p4_3_gpio_in : ext_external_interrupt_zero_select_n;
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt pin routing wrong.");
    property p_wdsel;
        watchdog_clock_select == $past(mode_q[5]);
    endproperty
    a_wdsel: assert property (p_wdsel)
        else $error("Watchdog source select wrong.");
    c_pwm: cover property (mode_q[0] && pwm_in);
    c_irq: cover property (mode_q[3] && !ext_external_interrupt_zero_select_n);
    c_wd: cover property (watchdog_clock_select);
endmodule // pgp_port_checker

bind pgp_port pgp_port_checker u_chk (
    .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pin_out, .pin_oe, .pin_pull_up, .pwm_in, .reset_out_req, .ext_external_interrupt_zero_select_n,
    .p4_3_gpio_in, .watchdog_clock_select
);

// file: pgp_board.sv
// Board model that sets the level seen on each port pin.
`timescale 1ns/1ps
module pgp_board (
    input wire logic ref_clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pull_up,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    // A pin nobody drives and nothing pulls up shows a toggling pattern.
    logic [7:0] float_q = 8'h55;
    always @(posedge ref_clk)
        float_q <= ~float_q;
    always_comb
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
            | (~pin_oe & ~ext_en & (pin_pull_up | float_q));
endmodule // pgp_board

// file: pgp_port_tb_top.sv
// Self-checking testbench for the port pin function block.
`timescale 1ns/1ps
`include "pgp_cfg.svh"
module pgp_port_tb_top;
    import pgp_pkg::*;
    logic ref_clk, rst_n, reg_wr, reg_rd, pwm_in, reset_out_req;
    logic p4_3_pin_in, capture_trigger_input, cap_seen;
    logic event_count_low_input, event_count_high_input;
    logic count_direction_input, capture_trigger_filtered;
    logic ext_external_interrupt_zero_select_n, p4_3_gpio_in, watchdog_clock_select, watchdog_tick;
    pgp_addr_t reg_addr;
    pgp_byte_t reg_wdata, reg_rdata, ext_val, ext_en;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pull_up;
    logic [7:0] sub_q = 8'h00;
    int n_errors = 0;
    int compares = 0;
    int nt;
    pgp_port #(
        .WDOG_SYS_DIV(16),
        .WDOG_SUB_DIV(4)
    ) dut (
        .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pin_in, .pin_out, .pin_oe, .pin_pull_up, .p4_3_pin_in,
        .capture_trigger_input, .subclock_in(sub_q[2]), .pwm_in,
        .reset_out_req, .event_count_low_input, .event_count_high_input,
        .count_direction_input, .capture_trigger_filtered, .ext_external_interrupt_zero_select_n,
        .p4_3_gpio_in, .watchdog_clock_select, .watchdog_tick
    );
    pgp_board board (.ref_clk, .pin_out, .pin_oe, .pin_pull_up, .ext_val,
        .ext_en, .pin_in);
    initial
    begin
        ref_clk = 1'b0;
        forever
            #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        sub_q <= sub_q + 8'h01;
    always @(negedge ref_clk)
        if (capture_trigger_filtered === 1'b1)
            cap_seen = 1'b1;
    task automatic chk(input pgp_byte_t g, input pgp_byte_t e);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input pgp_addr_t a, input pgp_byte_t d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // Let an edge pass so the next call never re-drives the strobe
        // in the same time step.
        @(posedge ref_clk);
    endtask
    task automatic rd(input pgp_addr_t a, input pgp_byte_t e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, e);
        @(posedge ref_clk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic settle(input int n);
        cyc(n);
        @(negedge ref_clk);
    endtask
    task automatic ticks(input int lo, input int hi);
        nt = 0;
        repeat (320)
        begin
            @(negedge ref_clk);
            if (watchdog_tick === 1'b1)
                nt++;
        end
        @(posedge ref_clk);
        chk(8'(nt >= lo && nt <= hi), 8'h01);
    endtask
    task automatic pulse(input int n, input logic e);
        cap_seen = 1'b0;
        capture_trigger_input <= 1'b1;
        cyc(n);
        capture_trigger_input <= 1'b0;
        cyc(14);
        chk({7'h00, cap_seen}, {7'h00, e});
    endtask
    task automatic wrap_up();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        n_errors++;
        wrap_up();
    end
    initial
    begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        ext_val = 8'h03;
        ext_en = 8'h0f;
        pwm_in = 1'b0;
        reset_out_req = 1'b0;
        p4_3_pin_in = 1'b1;
        capture_trigger_input = 1'b0;
        cap_seen = 1'b0;
        cyc(20);
        rst_n <= 1'b1;
        rd(`PGP_ADDR_MODE, 8'h04);
        rd(`PGP_ADDR_PULL, 8'h00);
        rd(`PGP_ADDR_DIR, 8'hff);
        rd(16'hffcb, 8'h00);
        chk(pin_oe, 8'h04);
        chk(pin_out, 8'h04);
        wr(`PGP_ADDR_MODE, 8'h00);
        wr(`PGP_ADDR_DIR, 8'hff);
        rd(`PGP_ADDR_DATA, 8'h00);
        wr(`PGP_ADDR_DIR, 8'hf0);
        wr(`PGP_ADDR_DATA, 8'ha5);
        settle(4);
        chk(pin_oe, 8'hf0);
        chk(pin_out & pin_oe, 8'ha0);
        cyc(1);
        rd(`PGP_ADDR_DATA, 8'ha3);
        wr(`PGP_ADDR_PULL, 8'hff);
        settle(3);
        chk(pin_pull_up, 8'h0f);
        cyc(1);
        rd(`PGP_ADDR_PULL, 8'hff);
        rd(`PGP_ADDR_DIR, 8'hff);
        wr(`PGP_ADDR_DIR, 8'hff);
        wr(`PGP_ADDR_MODE, 8'h05);
        rd(`PGP_ADDR_MODE, 8'h05);
        reset_out_req <= 1'b1;
        settle(3);
        chk(pin_oe, 8'hff);
        chk(pin_out, 8'ha0);
        chk(pin_pull_up, 8'h00);
        cyc(1);
        pwm_in <= 1'b1;
        settle(2);
        chk(pin_out, 8'ha1);
        cyc(1);
        wr(`PGP_ADDR_MODE, 8'hc2);
        ext_en <= 8'hff;
        ext_val <= 8'hff;
        settle(5);
        chk(pin_oe, 8'h3d);
        chk({5'h00, event_count_low_input, event_count_high_input,
            count_direction_input}, 8'h07);
        cyc(1);
        // Pins 6 and 1 are high but latched low: the latch must win.
        rd(`PGP_ADDR_DATA, 8'ha5);
        wr(`PGP_ADDR_MODE, 8'h00);
        settle(4);
        chk({5'h00, event_count_low_input, event_count_high_input,
            count_direction_input}, 8'h00);
        cyc(1);
        p4_3_pin_in <= 1'b0;
        wr(`PGP_ADDR_MODE, 8'h08);
        settle(5);
        chk({6'h00, ext_external_interrupt_zero_select_n, p4_3_gpio_in}, 8'h00);
        cyc(1);
        p4_3_pin_in <= 1'b1;
        wr(`PGP_ADDR_MODE, 8'h00);
        settle(5);
        chk({6'h00, ext_external_interrupt_zero_select_n, p4_3_gpio_in}, 8'h03);
        cyc(1);
        ticks(19, 21);
        wr(`PGP_ADDR_MODE, 8'h20);
        settle(2);
        chk({7'h00, watchdog_clock_select}, 8'h01);
        cyc(1);
        ticks(9, 11);
        wr(`PGP_ADDR_MODE, 8'h00);
        pulse(2, 1'b1);
        wr(`PGP_ADDR_MODE, 8'h10);
        pulse(2, 1'b0);
        pulse(10, 1'b1);
        wrap_up();
    end
endmodule // pgp_port_tb_top
